// File: dout_consts.vh
// constants for the discrete output module logic
`ifndef DOUT_CONSTS_VH
`define DOUT_CONSTS_VH
// ==========================================
// register byte offsets
`define DOUT_OFF_CTRL 8'h00
`define DOUT_OFF_START 8'h04
`define DOUT_OFF_BUS 8'h08
`define DOUT_OFF_FAULT 8'h0c
`define DOUT_OFF_OUT 8'h10
`define DOUT_OFF_STAT 8'h14
// ==========================================
// control field positions
`define DOUT_CTRL_VAR_LO 0
`define DOUT_CTRL_VAR_HI 1
`define DOUT_CTRL_INV 2
`define DOUT_CTRL_SRC 3
`define DOUT_CTRL_TTL 4
// fault field positions
`define DOUT_FLT_CPU 0
`define DOUT_FLT_CHAIN 1
`define DOUT_FLT_PSU 2
// bus register fields: data 7:0, point address 17:8
`define DOUT_BUS_DATA_HI 7
`define DOUT_BUS_ADDR_LO 8
`define DOUT_BUS_ADDR_HI 17
// ==========================================
// module variants
`define DOUT_VAR_ISO 2'h0
`define DOUT_VAR_DC8 2'h1
`define DOUT_VAR_HD32 2'h2
// ==========================================
// reset values and point counts
`define DOUT_CTRL_RST 5'h00
`define DOUT_START_RST 10'h000
`define DOUT_ISO_POINTS 6
`define DOUT_GRP_POINTS 8
`define DOUT_HD_POINTS 32
// axi responses
`define DOUT_RESP_OKAY 2'h0
`define DOUT_RESP_SLVERR 2'h2
`endif

// File: dout_module.v
// discrete output module logic with axi4-lite register access
`timescale 1ns/1ps
`include "dout_consts.vh"

module dout_module #(
	parameter NPTS = 32,
	parameter AW = 10
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [AW-1:0] io_addr,
	input wire [7:0] io_data,
	input wire io_strobe,
	input wire cpu_fail,
	input wire chain_fail,
	input wire psu_fail,
	input wire [1:0] variant_sel,
	input wire polarity_select_jumper,
	input wire [NPTS-1:0] fuse_open,
	output reg [NPTS-1:0] out_drive,
	output reg [NPTS-1:0] out_level,
	output reg [NPTS-1:0] out_on_indicator,
	output reg [NPTS-1:0] fuse_blown_indicator,
	output reg invert_indicator
);

	// ==========================================
	// software registers
	reg [4:0] ctrl_reg;
	reg [AW-1:0] start_reg;
	reg [2:0] fault_reg;
	reg [NPTS-1:0] latch_reg;
	reg [2:0] flt_seen_reg;
	reg [AW-1:0] sw_addr_reg;
	reg [7:0] sw_data_reg;
	reg sw_stb_reg;
	reg have_aw_reg;
	reg have_w_reg;
	reg [7:0] aw_reg;
	reg [31:0] wd_reg;
	reg [3:0] ws_reg;
	reg [NPTS-1:0] latch_next;

	wire [1:0] var_w;
	wire inv_mode;
	wire force_off;
	wire stb;
	wire [AW-1:0] addr;
	wire [7:0] data;
	wire [AW-1:0] offs;
	wire [AW-1:0] span;
	wire hit;
	wire [7:0] data_x;
	wire [1:0] grp;
	wire [2:0] bit_ix;
	wire do_write;
	wire [NPTS-1:0] on_w;

	// ==========================================
	// window sizes held at address width so the compare never pads
	localparam [AW-1:0] ISO_SPAN = `DOUT_ISO_POINTS;
	localparam [AW-1:0] DC8_SPAN = `DOUT_GRP_POINTS;
	localparam [AW-1:0] HD_SPAN = `DOUT_HD_POINTS;

	// hardware straps or software override of the variant
	// ored, so software can only add bits to what the strap sets
	assign var_w = ctrl_reg[`DOUT_CTRL_VAR_HI:`DOUT_CTRL_VAR_LO] | variant_sel;
	// hd only: jumper a-b (low) means inverting; software bit can also force it
	assign inv_mode = (~polarity_select_jumper | ctrl_reg[`DOUT_CTRL_INV]) &&
		(var_w == `DOUT_VAR_HD32);
	// iso ignores psu fail, dc8/hd honour all three
	// kept combinational so a failure blanks the pins on the next edge
	assign force_off = cpu_fail | chain_fail | fault_reg[`DOUT_FLT_CPU] |
		fault_reg[`DOUT_FLT_CHAIN] |
		((var_w != `DOUT_VAR_ISO) & (psu_fail | fault_reg[`DOUT_FLT_PSU]));

	// ==========================================
	// point decode, backplane strobe has priority over software
	assign stb = io_strobe | sw_stb_reg;
	assign addr = io_strobe ? io_addr : sw_addr_reg;
	assign data = io_strobe ? io_data : sw_data_reg;
	assign offs = addr - start_reg;
	assign span = (var_w == `DOUT_VAR_ISO) ? ISO_SPAN :
		(var_w == `DOUT_VAR_DC8) ? DC8_SPAN : HD_SPAN;
	assign hit = stb && (addr >= start_reg) && (offs < span);
	assign grp = offs[4:3];
	assign bit_ix = offs[2:0];
	assign data_x = inv_mode ? ~data : data;

	// latch update: hd writes a whole group per cycle, others one point
	// unused upper points are masked so a variant change leaves none lit
	always @* begin
		latch_next = latch_reg;
		if (force_off) begin
			latch_next = {NPTS{1'b0}};
		end else if (hit) begin
			if (var_w == `DOUT_VAR_HD32) begin
				latch_next[grp*8 +: 8] = data_x;
			end else begin
				latch_next[bit_ix] = data_x[0];
			end
		end
		if (var_w == `DOUT_VAR_ISO) begin
			latch_next[NPTS-1:`DOUT_ISO_POINTS] = {(NPTS-`DOUT_ISO_POINTS){1'b0}};
		end else if (var_w == `DOUT_VAR_DC8) begin
			latch_next[NPTS-1:`DOUT_GRP_POINTS] = {(NPTS-`DOUT_GRP_POINTS){1'b0}};
		end
	end

	// outputs held until readdressed or failed
	always @(posedge aclk) begin
		if (!aresetn) begin
			latch_reg <= {NPTS{1'b0}};
		end else begin
			latch_reg <= latch_next;
		end
	end

	assign on_w = force_off ? {NPTS{1'b0}} : latch_reg;

	// ==========================================
	// pin stage, per point
	// level and indicators share one register stage with the drive bit
	genvar gi;
	generate
		for (gi = 0; gi < NPTS; gi = gi + 1) begin : g_pt
			always @(posedge aclk) begin
				if (!aresetn) begin
					out_drive[gi] <= 1'b0;
					out_level[gi] <= 1'b0;
					out_on_indicator[gi] <= 1'b0;
					fuse_blown_indicator[gi] <= 1'b0;
				end else begin
					out_drive[gi] <= on_w[gi];
					// sink and ttl pull low when on, source pulls high
					out_level[gi] <= on_w[gi] & ctrl_reg[`DOUT_CTRL_SRC] &
						~ctrl_reg[`DOUT_CTRL_TTL];
					out_on_indicator[gi] <= on_w[gi];
					fuse_blown_indicator[gi] <= fuse_open[gi];
				end
			end
		end
	endgenerate

	// indicator follows the mode one edge later, like the pin stage
	always @(posedge aclk) begin
		if (!aresetn) begin
			invert_indicator <= 1'b0;
		end else begin
			invert_indicator <= inv_mode;
		end
	end

	// ==========================================
	// axi4-lite write: address and data in any order
	// one write in flight: both readies stay low until the response is taken
	assign do_write = have_aw_reg && have_w_reg && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DOUT_RESP_OKAY;
			have_aw_reg <= 1'b0;
			have_w_reg <= 1'b0;
			aw_reg <= 8'h00;
			wd_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			ctrl_reg <= `DOUT_CTRL_RST;
			start_reg <= `DOUT_START_RST;
			fault_reg <= 3'h0;
			sw_stb_reg <= 1'b0;
			sw_addr_reg <= {AW{1'b0}};
			sw_data_reg <= 8'h00;
		end else begin
			sw_stb_reg <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_reg <= s_axi_awaddr;
				have_aw_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd_reg <= s_axi_wdata;
				ws_reg <= s_axi_wstrb;
				have_w_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				have_aw_reg <= 1'b0;
				have_w_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `DOUT_RESP_OKAY;
				// decode on the word index; every offset is word aligned
				if (aw_reg[7:2] == `DOUT_OFF_CTRL >> 2) begin
					if (ws_reg[0]) ctrl_reg <= wd_reg[4:0];
				end else if (aw_reg[7:2] == `DOUT_OFF_START >> 2) begin
					if (ws_reg[0]) start_reg[7:0] <= wd_reg[7:0];
					if (ws_reg[1]) start_reg[AW-1:8] <= wd_reg[AW-1:8];
				end else if (aw_reg[7:2] == `DOUT_OFF_BUS >> 2) begin
					sw_data_reg <= wd_reg[`DOUT_BUS_DATA_HI:0];
					sw_addr_reg <= wd_reg[`DOUT_BUS_ADDR_HI:`DOUT_BUS_ADDR_LO];
					sw_stb_reg <= 1'b1;
				end else if (aw_reg[7:2] == `DOUT_OFF_FAULT >> 2) begin
					if (ws_reg[0]) fault_reg <= wd_reg[2:0];
				end else if (aw_reg[7:2] == `DOUT_OFF_OUT >> 2) begin
					s_axi_bresp <= `DOUT_RESP_OKAY; // read-only, write ignored
				end else if (aw_reg[7:2] == `DOUT_OFF_STAT >> 2) begin
					s_axi_bresp <= `DOUT_RESP_OKAY;
				end else begin
					s_axi_bresp <= `DOUT_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// sticky record of failures seen; hardware set beats software clear
	// cleared on the address handshake, while the old value is answered
	always @(posedge aclk) begin
		if (!aresetn) begin
			flt_seen_reg <= 3'h0;
		end else begin
			flt_seen_reg <= (flt_seen_reg &
				~((s_axi_arvalid && s_axi_arready &&
				s_axi_araddr[7:2] == `DOUT_OFF_STAT >> 2) ? 3'h7 : 3'h0)) |
				{psu_fail, chain_fail, cpu_fail};
		end
	end

	// ==========================================
	// axi4-lite read, answer one cycle after address
	// rdata cleared first so unused bits of every register read as zero
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `DOUT_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `DOUT_RESP_OKAY;
				s_axi_rdata <= 32'h0000_0000;
				if (s_axi_araddr[7:2] == `DOUT_OFF_CTRL >> 2) begin
					s_axi_rdata[4:0] <= ctrl_reg;
				end else if (s_axi_araddr[7:2] == `DOUT_OFF_START >> 2) begin
					s_axi_rdata[AW-1:0] <= start_reg;
				end else if (s_axi_araddr[7:2] == `DOUT_OFF_BUS >> 2) begin
					s_axi_rdata[`DOUT_BUS_ADDR_HI:0] <= {sw_addr_reg, sw_data_reg};
				end else if (s_axi_araddr[7:2] == `DOUT_OFF_FAULT >> 2) begin
					s_axi_rdata[2:0] <= fault_reg;
				end else if (s_axi_araddr[7:2] == `DOUT_OFF_OUT >> 2) begin
					s_axi_rdata[NPTS-1:0] <= on_w;
				end else if (s_axi_araddr[7:2] == `DOUT_OFF_STAT >> 2) begin
					s_axi_rdata[7:0] <= {1'b0, var_w, inv_mode, force_off, flt_seen_reg};
				end else begin
					s_axi_rresp <= `DOUT_RESP_SLVERR;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // dout_module

// File: dout_io_scan.sv
// cpu scan model driving points and groups into the output module
`timescale 1ns/1ps
module dout_io_scan (
	input wire aclk,
	output logic [9:0] io_addr,
	output logic [7:0] io_data,
	output logic io_strobe
);
// ====================
// scan cycle
// idle bus starts scrambled, never at a legal looking value
initial begin
	io_addr = 10'h3ff;
	io_data = 8'h5a;
	io_strobe = 1'h0;
end
// strobe high one cycle per transfer, then low one cycle; released lines show the inverse so stale data never helps
task automatic put(input logic [9:0] a, input logic [7:0] d);
	@(posedge aclk);
	io_addr <= a;
	io_data <= d;
	io_strobe <= 1'h1;
	@(posedge aclk);
	io_strobe <= 1'h0;
	io_addr <= ~a;
	io_data <= ~d;
endtask
endmodule // dout_io_scan

// File: dout_module_properties.sv
// port checker for the discrete output module
`timescale 1ns/1ps
module dout_props #(parameter NPTS = 32) (
	input wire aclk,
	input wire aresetn,
	input wire cpu_fail,
	input wire chain_fail,
	input wire psu_fail,
	input wire io_strobe,
	input wire s_axi_wvalid,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire [1:0] variant_sel,
	input wire polarity_select_jumper,
	input wire [NPTS-1:0] fuse_open,
	input wire [NPTS-1:0] out_drive,
	input wire [NPTS-1:0] out_on_indicator,
	input wire [NPTS-1:0] fuse_blown_indicator,
	input wire invert_indicator
);
// ====================
// port relations
// one clock domain, so shared clocking and reset
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
property p_fail_off; (cpu_fail || chain_fail)[*2] |=> out_drive == '0; endproperty
a_fail_off: assert property (p_fail_off) else $error("outputs on during failure");
property p_psu_off; (psu_fail && variant_sel == 2'h1)[*2] |=> out_drive == '0; endproperty
a_psu_off: assert property (p_psu_off) else $error("dc8 outputs on in psu fail");
property p_on_ind; out_on_indicator == out_drive; endproperty
a_on_ind: assert property (p_on_ind) else $error("on indicator differs");
property p_fuse; $past(aresetn) |-> fuse_blown_indicator == $past(fuse_open); endproperty
a_fuse: assert property (p_fuse) else $error("fuse indicator late");
property p_inv;
	(variant_sel == 2'h2 && $stable(polarity_select_jumper))[*3]
	|-> invert_indicator != polarity_select_jumper;
endproperty
a_inv: assert property (p_inv) else $error("invert indicator wrong");
// five quiet cycles cover the bus register path, pins move three edges after the take
property p_hold;
	(!io_strobe && !s_axi_wvalid && !cpu_fail && !chain_fail && !psu_fail
	&& $stable(variant_sel) && $stable(polarity_select_jumper))[*5] |-> $stable(out_drive);
endproperty
a_hold: assert property (p_hold) else $error("outputs moved unaddressed");
property p_bstand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
a_bstand: assert property (p_bstand) else $error("bvalid dropped");
property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
a_rlat: assert property (p_rlat) else $error("read answer late");
endmodule // dout_props
bind dout_module dout_props #(.NPTS(NPTS)) u_props (
	.aclk(aclk), .aresetn(aresetn), .cpu_fail(cpu_fail), .chain_fail(chain_fail),
	.psu_fail(psu_fail), .io_strobe(io_strobe), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .variant_sel(variant_sel),
	.polarity_select_jumper(polarity_select_jumper), .fuse_open(fuse_open),
	.out_drive(out_drive), .out_on_indicator(out_on_indicator),
	.fuse_blown_indicator(fuse_blown_indicator), .invert_indicator(invert_indicator)
);

// File: tb_top.sv
// self-checking bench for the discrete output module
`timescale 1ns/1ps
`include "dout_consts.vh"
module tb_top;
logic aclk = 1'h0;
logic aresetn = 1'h0;
logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
logic [31:0] s_axi_wdata = '0, fuse_open = '0, rv;
logic cpu_fail = 1'h0, chain_fail = 1'h0, psu_fail = 1'h0, polarity_select_jumper = 1'h1;
logic [1:0] variant_sel = 2'h0, rr, br;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire io_strobe, invert_indicator;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata, out_drive, out_level, out_on_indicator, fuse_blown_indicator;
wire [9:0] io_addr;
wire [7:0] io_data;
int err_count = 0, num_checks = 0, cyc = 0;
// ====================
// structure
dout_module u_dut (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.io_addr(io_addr), .io_data(io_data), .io_strobe(io_strobe),
	.cpu_fail(cpu_fail), .chain_fail(chain_fail), .psu_fail(psu_fail),
	.variant_sel(variant_sel), .polarity_select_jumper(polarity_select_jumper),
	.fuse_open(fuse_open), .out_drive(out_drive), .out_level(out_level),
	.out_on_indicator(out_on_indicator), .fuse_blown_indicator(fuse_blown_indicator),
	.invert_indicator(invert_indicator)
);
dout_io_scan u_scan (.aclk(aclk), .io_addr(io_addr), .io_data(io_data), .io_strobe(io_strobe));
// 200 MHz clock
always #2.5 aclk = ~aclk;
// hang guard well above the under two hundred cycles needed
always @(posedge aclk) begin
	cyc++;
	if (cyc == 20000) begin
		err_count++;
		close_out();
	end
end
// ====================
// helpers
task automatic close_out;
	$display("checks %0d errors %0d", num_checks, err_count);
	if (err_count == 0 && num_checks > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
endtask
task automatic tk(input int n);
	repeat (n) @(posedge aclk);
endtask
task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
	num_checks++;
	if (got !== exp) begin
		err_count++;
		$display("wrong value %s exp %h got %h", nm, exp, got);
	end
endtask
// address and data offered together, each dropped once taken
task automatic wr(input logic [7:0] a, input logic [31:0] d);
	@(posedge aclk);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'h1;
	s_axi_wvalid <= 1'h1;
	s_axi_bready <= 1'h1;
	do begin
		@(posedge aclk);
		if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
		if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
	end while (s_axi_bvalid !== 1'h1);
	br = s_axi_bresp;
	s_axi_bready <= 1'h0;
endtask
task automatic rd(input logic [7:0] a);
	@(posedge aclk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'h1;
	s_axi_rready <= 1'h1;
	do begin
		@(posedge aclk);
		if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
	end while (s_axi_rvalid !== 1'h1);
	rv = s_axi_rdata;
	rr = s_axi_rresp;
	s_axi_rready <= 1'h0;
endtask
// ====================
// scenarios
// eight-point module: window edges, pin polarity, fuse and supply failure
task automatic sc_dc8;
	variant_sel <= 2'h1;
	wr(`DOUT_OFF_START, 32'h10);
	u_scan.put(10'h010, 8'h01);
	u_scan.put(10'h012, 8'hff);
	u_scan.put(10'h013, 8'h00);
	u_scan.put(10'h018, 8'h01);
	u_scan.put(10'h00f, 8'h01);
	tk(3);
	chk("dc8 out", out_drive, 32'h5);
	rd(`DOUT_OFF_OUT);
	chk("out reg", rv, 32'h5);
	chk("on ind", out_on_indicator, 32'h5);
	wr(`DOUT_OFF_CTRL, 32'h8);
	tk(2);
	chk("src level", out_level, 32'h5);
	wr(`DOUT_OFF_CTRL, 32'h0);
	tk(2);
	chk("sink level", out_level, 32'h0);
	fuse_open <= 32'h81;
	tk(2);
	chk("fuse ind", fuse_blown_indicator, 32'h81);
	psu_fail <= 1'h1;
	tk(3);
	chk("psu off", out_drive, 32'h0);
	psu_fail <= 1'h0;
	tk(3);
	chk("held off", out_drive, 32'h0);
endtask
// isolated module: only six of the eight addressed points
task automatic sc_iso;
	variant_sel <= 2'h0;
	wr(`DOUT_OFF_START, 32'h20);
	for (int i = 0; i < 8; i++) u_scan.put(10'(10'h020 + i), 8'h01);
	tk(3);
	chk("iso out", out_drive, 32'h3f);
	cpu_fail <= 1'h1;
	tk(3);
	chk("cpu off", out_drive, 32'h0);
	cpu_fail <= 1'h0;
endtask
// high density: group order, polarity jumper, ttl level, registers
task automatic sc_hd;
	variant_sel <= 2'h2;
	wr(`DOUT_OFF_START, 32'h40);
	u_scan.put(10'h040, 8'h11);
	u_scan.put(10'h049, 8'h22);
	u_scan.put(10'h052, 8'h44);
	u_scan.put(10'h05f, 8'h88);
	u_scan.put(10'h060, 8'hff);
	tk(3);
	chk("hd groups", out_drive, 32'h88442211);
	chk("noninv ind", {31'h0, invert_indicator}, 32'h0);
	polarity_select_jumper <= 1'h0;
	u_scan.put(10'h040, 8'h0f);
	tk(3);
	chk("inv data", out_drive, 32'h884422f0);
	chk("inv ind", {31'h0, invert_indicator}, 32'h1);
	polarity_select_jumper <= 1'h1;
	wr(`DOUT_OFF_CTRL, 32'h10);
	tk(2);
	chk("ttl level", out_level, 32'h0);
	chain_fail <= 1'h1;
	tk(3);
	chk("chain off", out_drive, 32'h0);
	chain_fail <= 1'h0;
	rd(`DOUT_OFF_START);
	chk("start reg", rv, 32'h40);
	rd(8'h18);
	chk("bad addr", {30'h0, rr}, {30'h0, `DOUT_RESP_SLVERR});
endtask
// register path: software strobe, software failure, sticky status, bad write
task automatic sc_regs;
	wr(`DOUT_OFF_BUS, 32'h0000_485a);
	chk("bus bresp", {30'h0, br}, {30'h0, `DOUT_RESP_OKAY});
	tk(3);
	chk("bus path", out_drive, 32'h0000_5a00);
	rd(`DOUT_OFF_BUS);
	chk("bus reg", rv, 32'h0000_485a);
	chk("bus rresp", {30'h0, rr}, {30'h0, `DOUT_RESP_OKAY});
	wr(`DOUT_OFF_FAULT, 32'h1);
	tk(2);
	chk("sw cpu off", out_drive, 32'h0);
	rd(`DOUT_OFF_STAT);
	chk("stat sticky", rv, 32'h4f);
	rd(`DOUT_OFF_STAT);
	chk("stat cleared", rv, 32'h48);
	wr(`DOUT_OFF_FAULT, 32'h0);
	tk(3);
	chk("data lost", out_drive, 32'h0);
	wr(8'h1c, 32'h0);
	chk("bad wr", {30'h0, br}, {30'h0, `DOUT_RESP_SLVERR});
endtask
// ====================
// main sequence
initial begin
	repeat (6) @(posedge aclk);
	aresetn <= 1'h1;
	sc_dc8();
	sc_iso();
	sc_hd();
	sc_regs();
	close_out();
end
endmodule // tb_top
